// File: rtl/aex_pkg.sv
package aex_pkg;

  // register byte offsets on the apb bus
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_PTR = 8'h14;
  localparam logic [7:0] OFS_RES = 8'h18;

  // field positions
  localparam int CTRL_GO = 31;
  localparam int RES_BUSY = 16;
  localparam int RES_TAKEN = 17;
  localparam int RES_WB = 18;

  // flag_ff bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // reset values
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // cycle counts and program counter steps
  localparam int CYC_W = 3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] SKIP_ONE = 16'h0002;
  localparam logic [15:0] SKIP_TWO = 16'h0003;

  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADD_CARRY, OP_WORD_PLUS_IMM, OP_SUB, OP_DIFF_IMM,
    OP_DIFF_WITH_BORROW, OP_DIFF_IMM_BORROW, OP_WORD_MINUS_IMM, OP_AND,
    OP_CONJ_IMM, OP_OR, OP_DISJ_IMM, OP_XOR_REGS, OP_BIT_INVERT,
    OP_SIGN_INVERT, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_INC, OP_DEC,
    OP_ZERO_SIGN_PROBE, OP_ZERO_FILL, OP_FILL_ONES, OP_REL_JUMP,
    OP_IND_JUMP, OP_REL_CALL, OP_IND_CALL, OP_SUB_EXIT, OP_IRQ_EXIT,
    OP_EQ_SKIP, OP_COMPARE_REGS, OP_COMPARE_BORROW, OP_COMPARE_IMM,
    OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW,
    OP_SKIP_IO_BIT_HIGH, OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
    OP_BRANCH_ZERO_SET, OP_BRANCH_ZERO_CLEAR
  } aex_op_e;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} aex_state_e;

  // operand register a: io byte, pair high, destination
  typedef struct packed {
    logic [7:0] io;
    logic [7:0] hi;
    logic [7:0] lo;
  } aex_opa_s;

  // operand register b: offset, two-word next, bit select, source or K
  typedef struct packed {
    logic [11:0] ofs;
    logic two_word;
    logic [2:0] sel;
    logic [7:0] src;
  } aex_opb_s;

  typedef struct packed {
    logic [7:0] sum;
    logic c;
    logic h;
    logic v;
  } aex_alu_s;

endpackage

// File: rtl/aex_alu.sv
`timescale 1ns/10ps
module aex_alu
  import aex_pkg::*;
(
  input logic [7:0] a,
  input logic [7:0] b,
  input logic cin,
  input logic sub,
  output aex_alu_s res
);
  logic [8:0] full;
  logic [4:0] low;

  // one byte of add or subtract; carry in means borrow when subtracting
  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    res.sum = full[7:0];
    res.c = full[8];
    res.h = low[4];
    res.v = sub ? ((a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]))
                : ((a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]));
  end
endmodule // aex_alu

// File: rtl/aex_cyc.sv
`timescale 1ns/10ps
module aex_cyc #(
  parameter int W = 3
) (
  input logic pclk,
  input logic presetn,
  input logic load,
  input logic [W-1:0] value,
  input logic step,
  output logic last
);
  logic [W-1:0] cnt_ff;

  // counts down the remaining cycles of an instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= value;
    end else if (step && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign last = (cnt_ff == '0);
endmodule // aex_cyc

// File: rtl/aex_exec.sv
`timescale 1ns/10ps
module aex_exec
  import aex_pkg::*;
#(
  parameter int ADDR_W = APB_ADDR_W
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  aex_state_e state_ff;
  aex_op_e op_ff;
  aex_opa_s opa_ff;
  aex_opb_s opb_ff;
  logic [15:0] pc_ff;
  logic [15:0] z_ff;
  logic [15:0] stk_ff;
  logic [15:0] res_ff;
  logic [7:0] flag_ff;
  logic taken_ff;
  logic wb_ff;
  logic [31:0] prdata_ff;

  logic busy;
  logic wr_acc;
  logic launch;
  logic mapped;
  logic last;
  logic commit;
  logic [7:0] sel_addr;
  logic [31:0] rd_mux;
  aex_op_e cur_op;

  logic [15:0] nxt_res;
  logic [15:0] nxt_pc;
  logic [7:0] nxt_flag;
  logic nxt_taken;
  logic wr_lo;
  logic wr_hi;
  logic [2:0] cyc;

  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_sub;
  aex_alu_s lo_out;
  aex_alu_s hi_out;
  logic [7:0] logic_res;
  logic is_cmp;
  logic brw;
  logic [15:0] rel_pc;
  logic [15:0] skip_pc;
  logic [2:0] skip_cyc;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb decode; the slave always answers in the first access cycle
  assign busy = (state_ff == ST_BUSY);
  assign sel_addr = 8'(paddr);
  assign wr_acc = psel && penable && pwrite && !busy;
  assign launch = wr_acc && sel_addr == OFS_CTRL && pwdata[CTRL_GO];
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign commit = busy && last;

  always_comb begin
    case (sel_addr)
      OFS_CTRL, OFS_OPA, OFS_OPB, OFS_PC, OFS_FLAG, OFS_PTR, OFS_RES: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // writes while busy are refused so operands stay stable in flight
  assign pslverr = psel && penable && (!mapped || (pwrite && busy));

  // read mux; captured in setup so the access phase sees stable data
  always_comb begin
    case (sel_addr)
      OFS_CTRL: rd_mux = {26'h0, op_ff};
      OFS_OPA: rd_mux = {8'h00, opa_ff};
      OFS_OPB: rd_mux = {8'h00, opb_ff};
      OFS_PC: rd_mux = {16'h0000, pc_ff};
      OFS_FLAG: rd_mux = {24'h000000, flag_ff};
      OFS_PTR: rd_mux = {stk_ff, z_ff};
      OFS_RES: rd_mux = {13'h0, wb_ff, taken_ff, busy, res_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // opcode in flight: the launching write, then the latched copy
  assign cur_op = busy ? op_ff : aex_op_e'(pwdata[5:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff <= OP_ADD;
    end else if (wr_acc && sel_addr == OFS_CTRL) begin
      op_ff <= aex_op_e'(pwdata[5:0]);
    end
  end

  // sequencer: idle until launched, busy for the instruction's cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (launch) begin
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (last) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  aex_cyc #(
    .W(CYC_W)
  ) u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .load(launch),
    .value(cyc - 3'h1),
    .step(busy),
    .last(last)
  );

  // operand steering for the byte adder
  assign brw = cur_op inside {OP_DIFF_WITH_BORROW, OP_DIFF_IMM_BORROW, OP_COMPARE_BORROW};
  assign is_cmp = cur_op inside {OP_COMPARE_REGS, OP_COMPARE_BORROW, OP_COMPARE_IMM};

  always_comb begin
    alu_a = opa_ff.lo;
    alu_b = opb_ff.src;
    alu_cin = 1'b0;
    alu_sub = 1'b0;
    case (cur_op)
      OP_ADD_CARRY: alu_cin = flag_ff[FL_C];
      OP_SUB, OP_DIFF_IMM, OP_COMPARE_REGS, OP_COMPARE_IMM: alu_sub = 1'b1;
      OP_DIFF_WITH_BORROW, OP_DIFF_IMM_BORROW, OP_COMPARE_BORROW: begin
        alu_sub = 1'b1;
        alu_cin = flag_ff[FL_C];
      end
      OP_WORD_PLUS_IMM: alu_b = {2'b00, opb_ff.src[5:0]};
      OP_WORD_MINUS_IMM: begin
        alu_b = {2'b00, opb_ff.src[5:0]};
        alu_sub = 1'b1;
      end
      OP_INC: alu_b = 8'h01;
      OP_DEC: begin
        alu_b = 8'h01;
        alu_sub = 1'b1;
      end
      OP_SIGN_INVERT: begin
        alu_a = 8'h00;
        alu_b = opa_ff.lo;
        alu_sub = 1'b1;
      end
      default: alu_sub = 1'b0;
    endcase
  end

  aex_alu u_alu_lo (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .sub(alu_sub),
    .res(lo_out)
  );

  // high byte of a pair only takes the low byte's carry or borrow
  aex_alu u_alu_hi (
    .a(opa_ff.hi),
    .b(8'h00),
    .cin(lo_out.c),
    .sub(alu_sub),
    .res(hi_out)
  );

  // bitwise group
  always_comb begin
    case (cur_op)
      OP_AND, OP_CONJ_IMM: logic_res = opa_ff.lo & opb_ff.src;
      OP_OR, OP_DISJ_IMM, OP_SET_MASK_BITS: logic_res = opa_ff.lo | opb_ff.src;
      OP_CLEAR_MASK_BITS: logic_res = opa_ff.lo & ~opb_ff.src;
      OP_XOR_REGS: logic_res = opa_ff.lo ^ opb_ff.src;
      OP_ZERO_SIGN_PROBE: logic_res = opa_ff.lo & opa_ff.lo;
      OP_ZERO_FILL: logic_res = opa_ff.lo ^ opa_ff.lo;
      default: logic_res = opa_ff.lo;
    endcase
  end

  assign rel_pc = pc_ff + {{4{opb_ff.ofs[11]}}, opb_ff.ofs} + PC_STEP;
  assign skip_pc = pc_ff + (opb_ff.two_word ? SKIP_TWO : SKIP_ONE);
  assign skip_cyc = opb_ff.two_word ? CYC_THREE : CYC_TWO;

  // result, flags, next pc and cycle count of the instruction
  always_comb begin
    nxt_res = {8'h00, lo_out.sum};
    nxt_flag = flag_ff;
    nxt_pc = pc_ff + PC_STEP;
    nxt_taken = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    cyc = CYC_ONE;
    case (cur_op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_DIFF_IMM, OP_DIFF_WITH_BORROW,
      OP_DIFF_IMM_BORROW, OP_SIGN_INVERT, OP_COMPARE_REGS,
      OP_COMPARE_BORROW, OP_COMPARE_IMM: begin
        wr_lo = !is_cmp;
        nxt_flag[FL_C] = lo_out.c;
        nxt_flag[FL_H] = lo_out.h;
        nxt_flag[FL_V] = lo_out.v;
        nxt_flag[FL_N] = lo_out.sum[7];
        // chained borrow forms only keep zero if the earlier bytes were zero
        nxt_flag[FL_Z] = (lo_out.sum == 8'h00) && (!brw || flag_ff[FL_Z]);
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
        nxt_res = {hi_out.sum, lo_out.sum};
        wr_lo = 1'b1;
        wr_hi = 1'b1;
        cyc = CYC_TWO;
        nxt_flag[FL_C] = hi_out.c;
        nxt_flag[FL_V] = hi_out.v;
        nxt_flag[FL_N] = hi_out.sum[7];
        nxt_flag[FL_Z] = ({hi_out.sum, lo_out.sum} == 16'h0000);
        nxt_flag[FL_S] = hi_out.sum[7] ^ hi_out.v;
      end
      OP_AND, OP_CONJ_IMM, OP_OR, OP_DISJ_IMM, OP_XOR_REGS, OP_SET_MASK_BITS,
      OP_CLEAR_MASK_BITS, OP_ZERO_SIGN_PROBE, OP_ZERO_FILL: begin
        nxt_res = {8'h00, logic_res};
        wr_lo = 1'b1;
        nxt_flag[FL_V] = 1'b0;
        nxt_flag[FL_N] = logic_res[7];
        nxt_flag[FL_Z] = (logic_res == 8'h00);
      end
      OP_INC, OP_DEC: begin
        wr_lo = 1'b1;
        nxt_flag[FL_V] = lo_out.v;
        nxt_flag[FL_N] = lo_out.sum[7];
        nxt_flag[FL_Z] = (lo_out.sum == 8'h00);
      end
      OP_BIT_INVERT: begin
        nxt_res = {8'h00, ~opa_ff.lo};
        wr_lo = 1'b1;
        nxt_flag[FL_C] = 1'b1;
        nxt_flag[FL_V] = 1'b0;
        nxt_flag[FL_N] = ~opa_ff.lo[7];
        nxt_flag[FL_Z] = (opa_ff.lo == 8'hFF);
      end
      OP_FILL_ONES: begin
        nxt_res = 16'h00FF;
        wr_lo = 1'b1;
      end
      OP_REL_JUMP, OP_REL_CALL: begin
        nxt_pc = rel_pc;
        nxt_res = pc_ff + PC_STEP;
        cyc = (cur_op == OP_REL_CALL) ? CYC_THREE : CYC_TWO;
      end
      OP_IND_JUMP, OP_IND_CALL: begin
        nxt_pc = z_ff;
        nxt_res = pc_ff + PC_STEP;
        cyc = (cur_op == OP_IND_CALL) ? CYC_THREE : CYC_TWO;
      end
      OP_SUB_EXIT, OP_IRQ_EXIT: begin
        nxt_pc = stk_ff;
        cyc = CYC_FOUR;
        nxt_flag[FL_I] = (cur_op == OP_IRQ_EXIT) | flag_ff[FL_I];
      end
      OP_EQ_SKIP: nxt_taken = (opa_ff.lo == opb_ff.src);
      OP_SKIP_REG_BIT_LOW: nxt_taken = !opb_ff.src[opb_ff.sel];
      OP_SKIP_REG_BIT_HIGH: nxt_taken = opb_ff.src[opb_ff.sel];
      OP_SKIP_IO_BIT_LOW: nxt_taken = !opa_ff.io[opb_ff.sel];
      OP_SKIP_IO_BIT_HIGH: nxt_taken = opa_ff.io[opb_ff.sel];
      OP_BRANCH_FLAG_HIGH: nxt_taken = flag_ff[opb_ff.sel];
      OP_BRANCH_FLAG_LOW: nxt_taken = !flag_ff[opb_ff.sel];
      OP_BRANCH_ZERO_SET: nxt_taken = flag_ff[FL_Z];
      OP_BRANCH_ZERO_CLEAR: nxt_taken = !flag_ff[FL_Z];
      default: cyc = CYC_ONE;
    endcase
    // skips and branches share one taken decision
    if (nxt_taken && cur_op inside {[OP_EQ_SKIP:OP_EQ_SKIP],
                                    [OP_SKIP_REG_BIT_LOW:OP_SKIP_IO_BIT_HIGH]}) begin
      nxt_pc = skip_pc;
      cyc = skip_cyc;
    end else if (nxt_taken) begin
      nxt_pc = rel_pc;
      cyc = CYC_TWO;
    end
  end

  // operand registers: software while idle, write-back at commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_ff <= '0;
      opb_ff <= '0;
      z_ff <= WORD_RST;
      stk_ff <= WORD_RST;
    end else if (commit) begin
      if (wr_lo) begin
        opa_ff.lo <= nxt_res[7:0];
      end
      if (wr_hi) begin
        opa_ff.hi <= nxt_res[15:8];
      end
    end else if (wr_acc) begin
      if (sel_addr == OFS_OPA) begin
        opa_ff <= pwdata[23:0];
      end
      if (sel_addr == OFS_OPB) begin
        opb_ff <= pwdata[23:0];
      end
      if (sel_addr == OFS_PTR) begin
        z_ff <= pwdata[15:0];
        stk_ff <= pwdata[31:16];
      end
    end
  end

  // program counter and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= WORD_RST;
      flag_ff <= FLAG_RST;
    end else if (commit) begin
      pc_ff <= nxt_pc;
      flag_ff <= nxt_flag;
    end else if (wr_acc) begin
      if (sel_addr == OFS_PC) begin
        pc_ff <= pwdata[15:0];
      end
      if (sel_addr == OFS_FLAG) begin
        flag_ff <= pwdata[7:0];
      end
    end
  end

  // result word and outcome bits shown to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_ff <= WORD_RST;
      taken_ff <= 1'b0;
      wb_ff <= 1'b0;
    end else if (commit) begin
      res_ff <= nxt_res;
      taken_ff <= nxt_taken;
      wb_ff <= wr_lo;
    end
  end

  chk_add_one_cycle: assert property (
    launch && cur_op == OP_ADD |-> ##1 busy ##1 !busy &&
      opa_ff.lo == 8'($past(opa_ff.lo, 2) + $past(opb_ff.src, 2)))
    else $error("add result or timing wrong");
  chk_word_two_cyc: assert property (
    launch && cur_op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM} |->
      ##1 busy [*2] ##1 !busy && flag_ff[FL_S] == (flag_ff[FL_N] ^ flag_ff[FL_V]))
    else $error("word op timing or sign flag wrong");
  chk_sub_borrow_flag: assert property (
    launch && cur_op == OP_SUB |->
      ##2 flag_ff[FL_C] == ($past(opa_ff.lo, 2) < $past(opb_ff.src, 2)))
    else $error("subtract borrow wrong");
  chk_xor_keeps_carry: assert property (
    launch && cur_op == OP_XOR_REGS |->
      ##2 !flag_ff[FL_V] && flag_ff[FL_C] == $past(flag_ff[FL_C], 2))
    else $error("xor flag update wrong");
  chk_mask_clear: assert property (
    launch && cur_op == OP_CLEAR_MASK_BITS |->
      ##2 (opa_ff.lo & $past(opb_ff.src, 2)) == 8'h00)
    else $error("mask bits not cleared");
  chk_inc_overflow: assert property (
    launch && cur_op == OP_INC && opa_ff.lo == 8'h7F |->
      ##2 flag_ff[FL_V] && opa_ff.lo == 8'h80)
    else $error("increment overflow wrong");
  chk_rel_call_pc: assert property (
    launch && cur_op == OP_REL_CALL |-> ##1 busy [*3] ##1 pc_ff == $past(rel_pc, 4))
    else $error("relative call target or timing wrong");
  chk_ind_jump_pc: assert property (
    launch && cur_op == OP_IND_JUMP |-> ##1 busy [*2] ##1 pc_ff == $past(z_ff, 3))
    else $error("indirect jump wrong");
  chk_skip_two_word: assert property (
    launch && cur_op == OP_EQ_SKIP && opa_ff.lo == opb_ff.src && opb_ff.two_word |->
      ##1 busy [*3] ##1 !busy && pc_ff == 16'($past(pc_ff, 4) + SKIP_TWO))
    else $error("equal skip wrong");
  chk_cmp_no_write: assert property (
    launch && is_cmp |-> ##2 opa_ff.lo == $past(opa_ff.lo, 2))
    else $error("compare wrote a result");
  chk_branch_not_taken: assert property (
    launch && cur_op == OP_BRANCH_ZERO_SET && !flag_ff[FL_Z] |->
      ##1 busy ##1 !busy && pc_ff == 16'($past(pc_ff, 2) + PC_STEP))
    else $error("untaken branch wrong");
  chk_io_skip_none: assert property (
    launch && cur_op == OP_SKIP_IO_BIT_LOW && opa_ff.io[opb_ff.sel] |->
      ##1 busy ##1 !busy && pc_ff == 16'($past(pc_ff, 2) + PC_STEP))
    else $error("io bit skip wrong");
  chk_fill_keeps_flags: assert property (
    launch && cur_op == OP_FILL_ONES |->
      ##2 opa_ff.lo == 8'hFF && flag_ff == $past(flag_ff, 2))
    else $error("fill ones wrong");
  chk_irq_exit: assert property (
    launch && cur_op == OP_IRQ_EXIT |->
      ##5 flag_ff[FL_I] && pc_ff == $past(stk_ff, 5))
    else $error("interrupt exit wrong");

endmodule // aex_exec

// File: tb/aex_exec_tb.sv
`timescale 1ns/10ps
module aex_exec_tb;
  import aex_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd_q;
  logic [31:0] res_q;
  logic err_q;
  int fail_count = 0;
  int n_tests = 0;

  // 125 MHz core clock
  always #4 pclk = ~pclk;

  aex_exec #(.ADDR_W(8)) u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // single exit point for normal end and watchdog
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; psel stays up so a following setup can come at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    penable <= 1'b0;
  endtask

  // load operands, launch, probe the busy window, poll, then compare state
  task automatic run(input aex_op_e op, input logic [23:0] opa, input logic [23:0] opb,
                     input logic [7:0] flg, input logic [31:0] ptr, input logic [23:0] e_opa,
                     input logic [7:0] e_flg, input logic [15:0] e_pc, input int ncyc);
    int k;
    xfer(1'b1, OFS_OPA, {8'h00, opa});
    xfer(1'b1, OFS_OPB, {8'h00, opb});
    xfer(1'b1, OFS_FLAG, {24'h0, flg});
    xfer(1'b1, OFS_PC, 32'h10);
    xfer(1'b1, OFS_PTR, ptr);
    xfer(1'b1, OFS_CTRL, (32'h1 << CTRL_GO) | 32'(op));
    // a write taken two edges after launch is refused only while still busy
    xfer(1'b1, OFS_RES, 32'h0);
    chk("busy refusal", {31'h0, err_q}, {31'h0, (ncyc >= 2)});
    k = 0;
    rd_q = 32'h0001_0000;
    while (rd_q[RES_BUSY] !== 1'b0 && k < 20) begin
      xfer(1'b0, OFS_RES, 32'h0);
      k++;
    end
    res_q = rd_q;
    chk("busy end", {31'h0, rd_q[RES_BUSY]}, 32'h0);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd_q, 32'(op));
    xfer(1'b0, OFS_OPA, 32'h0);
    chk("opa", rd_q, {8'h00, e_opa});
    xfer(1'b0, OFS_FLAG, 32'h0);
    chk("flag", rd_q, {24'h0, e_flg});
    xfer(1'b0, OFS_PC, 32'h0);
    chk("pc", rd_q, {16'h0, e_pc});
    $display("test %s done", op.name());
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, OFS_FLAG, 32'h0);
    chk("flag reset", rd_q, {24'h0, FLAG_RST});
    xfer(1'b0, OFS_PC, 32'h0);
    chk("pc reset", rd_q, {16'h0, WORD_RST});
    // unmapped place answers with an error and zero data
    xfer(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", {31'h0, err_q}, 32'h1);
    chk("unmapped data", rd_q, 32'h0);
    $display("test reset and map done");
    run(OP_ADD, 24'h0F, 24'h01, 8'h00, 32'h0, 24'h10, 8'h20, 16'h11, 1);
    run(OP_ADD_CARRY, 24'h7F, 24'h00, 8'h01, 32'h0, 24'h80, 8'h2C, 16'h11, 1);
    run(OP_SUB, 24'h10, 24'h10, 8'h00, 32'h0, 24'h00, 8'h02, 16'h11, 1);
    run(OP_DIFF_IMM, 24'h00, 24'h01, 8'h00, 32'h0, 24'hFF, 8'h25, 16'h11, 1);
    run(OP_XOR_REGS, 24'hF0, 24'hFF, 8'h09, 32'h0, 24'h0F, 8'h01, 16'h11, 1);
    run(OP_CLEAR_MASK_BITS, 24'hFF, 24'h0F, 8'h00, 32'h0, 24'hF0, 8'h04, 16'h11, 1);
    run(OP_DEC, 24'h80, 24'h00, 8'h00, 32'h0, 24'h7F, 8'h08, 16'h11, 1);
    run(OP_BIT_INVERT, 24'hFF, 24'h00, 8'h00, 32'h0, 24'h00, 8'h03, 16'h11, 1);
    run(OP_SIGN_INVERT, 24'h01, 24'h00, 8'h00, 32'h0, 24'hFF, 8'h25, 16'h11, 1);
    run(OP_FILL_ONES, 24'h00, 24'h00, 8'h2A, 32'h0, 24'hFF, 8'h2A, 16'h11, 1);
    run(OP_COMPARE_IMM, 24'h05, 24'h05, 8'h00, 32'h0, 24'h05, 8'h02, 16'h11, 1);
    run(OP_WORD_PLUS_IMM, 24'hFF, 24'h01, 8'h00, 32'h0, 24'h100, 8'h00, 16'h11, 2);
    run(OP_WORD_MINUS_IMM, 24'h00, 24'h01, 8'h00, 32'h0, 24'hFFFF, 8'h15, 16'h11, 2);
    run(OP_REL_JUMP, 24'h00, 24'hFFE000, 8'h2A, 32'h0, 24'h00, 8'h2A, 16'h0F, 2);
    run(OP_REL_CALL, 24'h00, 24'h005000, 8'h00, 32'h0, 24'h00, 8'h00, 16'h16, 3);
    chk("call return", {16'h0, res_q[15:0]}, 32'h11);
    run(OP_IND_JUMP, 24'h00, 24'h00, 8'h00, 32'h1234, 24'h00, 8'h00, 16'h1234, 2);
    run(OP_IND_CALL, 24'h00, 24'h00, 8'h00, 32'h40, 24'h00, 8'h00, 16'h40, 3);
    run(OP_SUB_EXIT, 24'h00, 24'h00, 8'h00, 32'hABC0000, 24'h00, 8'h00, 16'hABC, 4);
    run(OP_IRQ_EXIT, 24'h00, 24'h00, 8'h00, 32'hABC0000, 24'h00, 8'h80, 16'hABC, 4);
    run(OP_EQ_SKIP, 24'h33, 24'h833, 8'h00, 32'h0, 24'h33, 8'h00, 16'h13, 3);
    run(OP_EQ_SKIP, 24'h33, 24'h34, 8'h00, 32'h0, 24'h33, 8'h00, 16'h11, 1);
    run(OP_SKIP_REG_BIT_LOW, 24'hF7, 24'h3F7, 8'h00, 32'h0, 24'hF7, 8'h00, 16'h12, 2);
    run(OP_SKIP_REG_BIT_HIGH, 24'hF7, 24'h3F7, 8'h00, 32'h0, 24'hF7, 8'h00, 16'h11, 1);
    run(OP_SKIP_IO_BIT_HIGH, 24'h800000, 24'h700, 8'h00, 32'h0, 24'h800000, 8'h00, 16'h12,
        2);
    run(OP_SKIP_IO_BIT_LOW, 24'h800000, 24'h700, 8'h00, 32'h0, 24'h800000, 8'h00, 16'h11,
        1);
    run(OP_BRANCH_ZERO_SET, 24'h00, 24'h003000, 8'h02, 32'h0, 24'h00, 8'h02, 16'h14, 2);
    run(OP_BRANCH_ZERO_SET, 24'h00, 24'h003000, 8'h00, 32'h0, 24'h00, 8'h00, 16'h11, 1);
    run(OP_BRANCH_ZERO_CLEAR, 24'h00, 24'h003000, 8'h02, 32'h0, 24'h00, 8'h02, 16'h11,
        1);
    run(OP_INC, 24'h7F, 24'h00, 8'h00, 32'h0, 24'h80, 8'h0C, 16'h11, 1);
    run(OP_ZERO_FILL, 24'h5A, 24'h00, 8'h09, 32'h0, 24'h00, 8'h03, 16'h11, 1);
    run(OP_AND, 24'hF0, 24'h0F, 8'h00, 32'h0, 24'h00, 8'h02, 16'h11, 1);
    run(OP_SET_MASK_BITS, 24'h01, 24'h80, 8'h00, 32'h0, 24'h81, 8'h04, 16'h11, 1);
    run(OP_DIFF_WITH_BORROW, 24'h10, 24'h0F, 8'h03, 32'h0, 24'h00, 8'h22, 16'h11, 1);
    run(OP_COMPARE_BORROW, 24'h05, 24'h05, 8'h00, 32'h0, 24'h05, 8'h00, 16'h11, 1);
    run(OP_BRANCH_FLAG_LOW, 24'h00, 24'h002000, 8'h00, 32'h0, 24'h00, 8'h00, 16'h13, 2);
    run(OP_BRANCH_FLAG_HIGH, 24'h00, 24'h002000, 8'h00, 32'h0, 24'h00, 8'h00, 16'h11, 1);
    psel <= 1'b0;
    @(posedge pclk);
    final_report();
  end

  // the sequence needs well under 2000 cycles; a hang ends here instead
  initial begin
    #100000;
    fail_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    final_report();
  end
endmodule // aex_exec_tb
